// ===== bench/cbr_exec_monitor.sv
// Purpose: Port-level checks for the execution unit
// Assumes: Skip state rebuilt from taken test words
// Notes:   Bound to cbr_exec below
`timescale 1ns/10ps
module cbr_exec_monitor
  import cbr_pkg::*;
(
  input wire logic               core_clk,    // Clock
  input wire logic               nrst,        // Reset
  input wire logic               instr_valid, // Word valid
  input wire logic [INSTR_W-1:0] instr,       // Word
  input wire logic [DATA_W-1:0]  file_rdata,  // Read data
  input wire logic               call_push,   // Push
  input wire logic               instr_ready, // Ready
  input wire logic [FADDR_W-1:0] file_addr,   // Write address
  input wire logic               file_we,     // Write strobe
  input wire logic [DATA_W-1:0]  file_wdata,  // Write data
  input wire logic [PC_W-1:0]    pc,          // Program counter
  input wire logic [DATA_W-1:0]  acc,         // Accumulator
  input wire logic               carry,       // Carry
  input wire logic               global_interrupt_enable // Interrupt enable
);
  logic skip_r, skip_nxt, take, bit_v, is_ret;
  assign take   = instr_valid && instr_ready && !skip_r;
  assign bit_v  = file_rdata[instr[9:7]];
  assign is_ret = instr == OP_RET_V || instr == OP_RFI_V || (instr & OP_RLW_M) == OP_RLW_V;
  always_comb begin
    skip_nxt = skip_r;
    if (!nrst || (skip_r && instr_valid)) begin
      skip_nxt = 1'b0;
    end else if (take && (instr & OP_BIT_M) == OP_TSC_V) begin
      skip_nxt = !bit_v;
    end else if (take && (instr & OP_BIT_M) == OP_TSS_V) begin
      skip_nxt = bit_v;
    end
  end
  always_ff @(posedge core_clk) begin
    skip_r <= skip_nxt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_clr;
    take && (instr & OP_BIT_M) == OP_CLR_V |=> file_we && $stable(carry) && file_addr == $past(instr[6:0])
      && file_wdata == ($past(file_rdata) & ~(8'h01 << $past(instr[9:7]))) && $stable(acc);
  endproperty
  a_clr: assert property (p_clr) else $error("bit clear result wrong");
  property p_set;
    take && (instr & OP_BIT_M) == OP_SET_V |=> file_we && $stable(carry) && $stable(acc)
      && file_addr == $past(instr[6:0]) && file_wdata == ($past(file_rdata) | (8'h01 << $past(instr[9:7])));
  endproperty
  a_set: assert property (p_set) else $error("bit set result wrong");
  property p_skip;
    skip_r && instr_valid |=> pc == $past(pc) + 15'd1 && !file_we && $stable(acc);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped word executed");
  property p_rjl;
    take && (instr & OP_RJL_M) == OP_RJL_V
      |=> pc == $past(pc) + 15'd1 + 15'($signed($past(instr[8:0]))) && !instr_ready ##1 instr_ready;
  endproperty
  a_rjl: assert property (p_rjl) else $error("literal jump wrong");
  property p_rja;
    take && instr == OP_RJA_V |=> pc == $past(pc) + 15'd1 + 15'($past(acc)) && !instr_ready ##1 instr_ready;
  endproperty
  a_rja: assert property (p_rja) else $error("accumulator jump wrong");
  property p_ret;
    take && is_ret |=> !instr_ready && !file_we ##1 instr_ready;
  endproperty
  a_ret: assert property (p_ret) else $error("return timing wrong");
  property p_rfi;
    take && instr == OP_RFI_V |=> global_interrupt_enable;
  endproperty
  a_rfi: assert property (p_rfi) else $error("interrupt enable not set");
  property p_rlw;
    take && (instr & OP_RLW_M) == OP_RLW_V |=> acc == $past(instr[7:0]) && $stable(carry);
  endproperty
  a_rlw: assert property (p_rlw) else $error("literal return value wrong");
  property p_rot;
    take && (instr & OP_ROT_M) == OP_ROT_V |=> carry == $past(file_rdata[7])
      && (($past(instr[7]) && file_we && file_wdata == {$past(file_rdata[6:0]), $past(carry)})
      || (!$past(instr[7]) && !file_we && acc == {$past(file_rdata[6:0]), $past(carry)}));
  endproperty
  a_rot: assert property (p_rot) else $error("rotate result wrong");
  c_skip: cover property (skip_r && instr_valid);
  c_ret: cover property (take && is_ret);
  c_push: cover property (call_push);
endmodule

bind cbr_exec cbr_exec_monitor i_cbr_exec_monitor (.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid),
  .instr(instr), .file_rdata(file_rdata), .call_push(call_push), .instr_ready(instr_ready), .file_addr(file_addr),
  .file_we(file_we), .file_wdata(file_wdata), .pc(pc), .acc(acc), .carry(carry),
  .global_interrupt_enable(global_interrupt_enable));

// ===== bench/cbr_exec_tb.sv
// Purpose: Self-checking bench for the execution unit
// Assumes: File memory answers combinationally on instr[6:0]
// Notes:   Integer model and stack queue checked after every word
`timescale 1ns/10ps
module cbr_exec_tb;
  import cbr_pkg::*;
  logic               core_clk, nrst, instr_valid, call_push, instr_ready, file_we, carry, ien;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0]  file_rdata, file_wdata, acc;
  logic [FADDR_W-1:0] file_addr;
  logic [PC_W-1:0]    pc;
  logic [7:0]         mem [128];
  int                 num_errors, comparisons, epc, eacc, ec, eien, skip, stk[$];
  assign file_rdata = mem[instr[6:0]];
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  cbr_exec i_cbr_exec (.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .call_push(call_push), .instr_ready(instr_ready), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .pc(pc), .acc(acc), .carry(carry), .global_interrupt_enable(ien));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic push();
    instr_valid = 1'b0;
    call_push   = 1'b1;
    stk.push_back((epc + 1) & 32'h7fff);
    @(negedge core_clk);
    call_push = 1'b0;
    chk(pc, epc);
  endtask
  task automatic step(input logic [13:0] w);
    int f = int'(w[6:0]);
    int b = int'(w[9:7]);
    int v = int'(mem[f]);
    int we = 0;
    int wd = 0;
    int jmp = 0;
    int r;
    instr       = w;
    instr_valid = 1'b1;
    epc++;
    if (skip) begin
      skip = 0;
    end else begin
      casez (w)
        14'b01_00??_????_????: begin we = 1; wd = v & ~(1 << b); end
        14'b01_01??_????_????: begin we = 1; wd = v | (1 << b); end
        14'b01_10??_????_????: skip = v[b] == 0;
        14'b01_11??_????_????: skip = v[b];
        14'b11_001?_????_????: begin epc += w[8] ? int'(w[8:0]) - 512 : int'(w[8:0]); jmp = 1; end
        14'h000b: begin epc += eacc; jmp = 1; end
        14'h0008: begin epc = stk.pop_back(); jmp = 1; end
        14'h0009: begin epc = stk.pop_back(); eien = 1; jmp = 1; end
        14'b11_0100_????_????: begin epc = stk.pop_back(); eacc = int'(w[7:0]); jmp = 1; end
        14'b00_1101_????_????: begin
          r  = ((v << 1) | ec) & 255;
          ec = v[7];
          if (w[7]) begin we = 1; wd = r; end else eacc = r;
        end
        default: ;
      endcase
    end
    epc &= 32'h7fff;
    @(negedge core_clk);
    if (we) mem[f] = 8'(wd);
    chk(pc, epc);
    chk({acc, carry, ien}, eacc << 2 | ec << 1 | eien);
    chk({file_we, instr_ready}, we << 1 | !jmp);
    if (we) chk({file_addr, file_wdata}, f << 8 | wd);
    if (jmp) begin
      instr = 14'h1400 | 14'($urandom & 32'h3ff);
      @(negedge core_clk);
      chk({pc, file_we, instr_ready}, epc << 2 | 1);
    end
  endtask
  initial begin
    int k;
    nrst        = 1'b0;
    instr_valid = 1'b0;
    call_push   = 1'b0;
    instr       = '0;
    {num_errors, comparisons, epc, eacc, ec, eien, skip} = '0;
    void'($urandom(72294));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (4) @(negedge core_clk);
    chk({pc, acc, carry, ien, file_we, instr_ready}, 32'h1);
    nrst = 1'b1;
    for (int i = 0; i < 300; i++) begin
      k = $urandom % 5;
      step(k == 4 ? 14'h0d00 | 14'($urandom & 32'hff) : 14'h1000 | 14'(k << 10) | 14'($urandom & 32'h3ff));
    end
    step(14'h3300);
    step(14'h32ff);
    step(14'h000b);
    mem[3] = 8'h00;
    step(14'h1803);
    step(14'h3205);
    repeat (3) begin
      push();
      step(14'h3200 | 14'($urandom & 32'h1ff));
    end
    step(14'h3400 | 14'($urandom & 32'hff));
    step(14'h0009);
    step(14'h0008);
    finish_test();
  end
endmodule

// ===== src/cbr_exec.sv
// Purpose: Executes bit ops, bit tests, relative jumps, returns and rotate
// Assumes: One instruction offered per cycle with instr_valid; file data read combinationally
// Notes:   Two-cycle instructions hold instr_ready low for one cycle
//
// Operation
// RULE_01: Bit clear writes zero to bit b of file register f, keeping other bits and flags.
// RULE_02: Bit set writes one to bit b of file register f, keeping other bits and flags.
// RULE_03: Test-skip-when-clear discards the next instruction as a no-op when the bit is zero.
// RULE_04: Test-skip-when-set discards the next instruction as a no-op when the bit is one.
// RULE_05: Literal relative jump loads PC+1+k with k signed 9-bit, in two cycles.
// RULE_06: Accumulator relative jump loads PC+1+accumulator unsigned, in two cycles.
// RULE_07: Return from interrupt pops the stack into PC and sets global enable, in two cycles.
// RULE_08: Return from subroutine pops the stack into PC in two cycles, flags unchanged.
// RULE_09: Return with literal loads the accumulator with k and PC from the stack top, two cycles.
// RULE_10: Rotate left shifts f left through carry in one cycle.
// RULE_11: Rotate destination zero writes the accumulator, one writes the file register.
// RULE_12: Each return pop decrements the stack pointer.
`timescale 1ns/10ps
module cbr_exec
  import cbr_pkg::*;
(
  input  wire logic               core_clk,    // Core clock
  input  wire logic               nrst,        // Sync reset, active low
  input  wire logic               instr_valid, // Fetched word present
  input  wire logic [INSTR_W-1:0] instr,       // Fetched instruction word
  input  wire logic [DATA_W-1:0]  file_rdata,  // Data at the current word's f field, instr[6:0]
  input  wire logic               call_push,   // Push request from call logic
  output logic                    instr_ready, // Ready to take a word this cycle
  output logic      [FADDR_W-1:0] file_addr,   // File register address
  output logic                    file_we,     // File register write strobe
  output logic      [DATA_W-1:0]  file_wdata,  // File register write data
  output logic      [PC_W-1:0]    pc,          // Program counter
  output logic      [DATA_W-1:0]  acc,         // Accumulator
  output logic                    carry,       // Carry flag
  output logic                    global_interrupt_enable // Interrupt control bit
);

  function automatic cbr_op_e decode(input logic [INSTR_W-1:0] w);
    cbr_op_e op;
    op = CBR_OP_NONE;
    if ((w & OP_BIT_M) == OP_CLR_V) op = CBR_OP_CLR;
    else if ((w & OP_BIT_M) == OP_SET_V) op = CBR_OP_SET;
    else if ((w & OP_BIT_M) == OP_TSC_V) op = CBR_OP_TSC;
    else if ((w & OP_BIT_M) == OP_TSS_V) op = CBR_OP_TSS;
    else if ((w & OP_RJL_M) == OP_RJL_V) op = CBR_OP_RJL;
    else if ((w & OP_FULL_M) == OP_RJA_V) op = CBR_OP_RJA;
    else if ((w & OP_FULL_M) == OP_RFI_V) op = CBR_OP_RFI;
    else if ((w & OP_FULL_M) == OP_RET_V) op = CBR_OP_RET;
    else if ((w & OP_RLW_M) == OP_RLW_V) op = CBR_OP_RLW;
    return op;
  endfunction

  // One-hot mask for the selected bit
  function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] b);
    logic [DATA_W-1:0] m;
    m = '0;
    m[b] = 1'b1;
    return m;
  endfunction

  // Rotate is matched outside the decode table
  function automatic logic is_rotate(input logic [INSTR_W-1:0] w);
    return (w & OP_ROT_M) == OP_ROT_V;
  endfunction

  typedef enum logic [2:0] {
    ST_EXEC = 3'h1,
    ST_SKIP = 3'h2,
    ST_WAIT = 3'h4
  } cbr_state_e;

  cbr_state_e         state_r, state_nxt;
  logic [PC_W-1:0]    pc_r, pc_nxt;
  logic [DATA_W-1:0]  acc_r, acc_nxt;
  logic               c_r, c_nxt;
  logic               ien_r, ien_nxt;
  logic               rdy_r, rdy_nxt;
  logic               we_r, we_nxt;
  logic [DATA_W-1:0]  wd_r, wd_nxt;
  logic [FADDR_W-1:0] fa_r, fa_nxt;
  logic               pop;
  logic               exec_go;
  logic               skip_go;
  logic [PC_W-1:0]    stk_top;
  logic [PC_W-1:0]    pc_inc;
  cbr_op_e            op;
  logic [2:0]         bsel;
  logic [DATA_W-1:0]  rot;
  logic               rot_to_file;

  assign op          = decode(instr);
  assign bsel        = instr[B_LSB +: 3];
  assign pc_inc      = pc_r + 15'h0001;
  assign rot         = {file_rdata[DATA_W-2:0], c_r};
  assign rot_to_file = instr[D_BIT];

  cbr_stack u_stack (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .push      (call_push),
    .push_addr (pc_inc),
    .pop       (pop),
    .top_entry (stk_top)
  );

  // Word accepted for execution
  assign exec_go = (state_r == ST_EXEC) && instr_valid && rdy_r;
  // Word swallowed by a pending skip
  assign skip_go = (state_r == ST_SKIP) && instr_valid;

  // Sequencing state and ready
  always_comb begin
    state_nxt = state_r;
    rdy_nxt   = 1'b1;
    pop       = 1'b0;
    case (state_r)
      ST_EXEC: begin
        // Two-cycle transfers drop ready for one cycle
        if (exec_go) begin
          case (op)
            CBR_OP_TSC: begin
              if (!file_rdata[bsel]) begin
                state_nxt = ST_SKIP; // [RULE_03]
              end
            end
            CBR_OP_TSS: begin
              if (file_rdata[bsel]) begin
                state_nxt = ST_SKIP; // [RULE_04]
              end
            end
            CBR_OP_RJL, CBR_OP_RJA: begin
              state_nxt = ST_WAIT; // [RULE_05] [RULE_06]
              rdy_nxt   = 1'b0;
            end
            CBR_OP_RFI, CBR_OP_RET, CBR_OP_RLW: begin
              pop       = 1'b1; // [RULE_12]
              state_nxt = ST_WAIT; // [RULE_07] [RULE_08] [RULE_09]
              rdy_nxt   = 1'b0;
            end
            default: begin
              state_nxt = ST_EXEC;
            end
          endcase
        end
      end
      ST_SKIP: begin
        // Next word consumed as a no-op
        if (skip_go) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_WAIT: begin
        // Second cycle of a two-cycle transfer of control
        state_nxt = ST_EXEC;
      end
      default: begin
        state_nxt = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= ST_EXEC;
      rdy_r   <= 1'b1;
    end else begin
      state_r <= state_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  // Program counter
  always_comb begin
    pc_nxt = pc_r;
    if (skip_go) begin
      pc_nxt = pc_inc; // [RULE_03] [RULE_04]
    end else if (exec_go) begin
      case (op)
        CBR_OP_RJL: begin
          pc_nxt = pc_inc + PC_W'($signed(instr[K9_LSB +: K9_W])); // [RULE_05]
        end
        CBR_OP_RJA: begin
          pc_nxt = pc_inc + PC_W'(acc_r); // [RULE_06]
        end
        CBR_OP_RFI, CBR_OP_RET, CBR_OP_RLW: begin
          // Stack top is read before the pop lands
          pc_nxt = stk_top; // [RULE_07] [RULE_08] [RULE_09]
        end
        default: begin
          pc_nxt = pc_inc;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pc_r <= PC_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // Accumulator
  always_comb begin
    acc_nxt = acc_r;
    if (exec_go) begin
      if (op == CBR_OP_RLW) begin
        acc_nxt = instr[K8_LSB +: DATA_W]; // [RULE_09]
      end else if (is_rotate(instr) && !rot_to_file) begin
        acc_nxt = rot; // [RULE_11]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      acc_r <= ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Carry, changed only by the rotate
  always_comb begin
    c_nxt = c_r;
    if (exec_go && is_rotate(instr)) begin
      c_nxt = file_rdata[DATA_W-1]; // [RULE_10]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      c_r <= C_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Global interrupt enable, only ever set here
  always_comb begin
    ien_nxt = ien_r;
    if (exec_go && (op == CBR_OP_RFI)) begin
      ien_nxt = 1'b1; // [RULE_07]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ien_r <= IEN_RST;
    end else begin
      ien_r <= ien_nxt;
    end
  end

  // File register write port, one-cycle strobe
  always_comb begin
    we_nxt = 1'b0;
    wd_nxt = wd_r;
    // Address follows the word so the write lands where it was read
    fa_nxt = instr[F_LSB +: FADDR_W];
    if (exec_go) begin
      case (op)
        CBR_OP_CLR: begin
          we_nxt = 1'b1;
          wd_nxt = file_rdata & ~bit_mask(bsel); // [RULE_01]
        end
        CBR_OP_SET: begin
          we_nxt = 1'b1;
          wd_nxt = file_rdata | bit_mask(bsel); // [RULE_02]
        end
        default: begin
          if (is_rotate(instr) && rot_to_file) begin
            we_nxt = 1'b1; // [RULE_11]
            wd_nxt = rot;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      we_r <= 1'b0;
      wd_r <= ACC_RST;
      fa_r <= 7'h00;
    end else begin
      we_r <= we_nxt;
      wd_r <= wd_nxt;
      fa_r <= fa_nxt;
    end
  end

  assign instr_ready             = rdy_r;
  assign file_addr               = fa_r;
  assign file_we                 = we_r;
  assign file_wdata              = wd_r;
  assign pc                      = pc_r;
  assign acc                     = acc_r;
  assign carry                   = c_r;
  assign global_interrupt_enable = ien_r;

endmodule

// ===== src/cbr_pkg.sv
// Purpose: Shared constants for the branch, bit and return execution unit
// Assumes: 14-bit instruction words, 15-bit program counter, 8-bit data
// Notes:   Opcode patterns cover only the instructions this unit executes
package cbr_pkg;

  localparam int unsigned PC_W        = 15;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FADDR_W     = 7;
  localparam int unsigned INSTR_W     = 14;
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned SP_W        = 4;

  localparam logic [PC_W-1:0]    PC_RST  = 15'h0000;
  localparam logic [SP_W-1:0]    SP_RST  = 4'hf;
  localparam logic [DATA_W-1:0]  ACC_RST = 8'h00;
  localparam logic               IEN_RST = 1'b0;
  localparam logic               C_RST   = 1'b0;

  // Interrupt control register, global enable bit position
  localparam int unsigned IEN_BIT = 7;

  // Operand fields
  localparam int unsigned F_LSB   = 0;
  localparam int unsigned B_LSB   = 7;
  localparam int unsigned D_BIT   = 7;
  localparam int unsigned K9_LSB  = 0;
  localparam int unsigned K9_W    = 9;
  localparam int unsigned K8_LSB  = 0;

  // Opcode matches: value and mask
  localparam logic [INSTR_W-1:0] OP_CLR_V  = 14'h1000;
  localparam logic [INSTR_W-1:0] OP_SET_V  = 14'h1400;
  localparam logic [INSTR_W-1:0] OP_TSC_V  = 14'h1800;
  localparam logic [INSTR_W-1:0] OP_TSS_V  = 14'h1c00;
  localparam logic [INSTR_W-1:0] OP_BIT_M  = 14'h3c00;
  localparam logic [INSTR_W-1:0] OP_RJL_V  = 14'h3200;
  localparam logic [INSTR_W-1:0] OP_RJL_M  = 14'h3e00;
  localparam logic [INSTR_W-1:0] OP_RJA_V  = 14'h000b;
  localparam logic [INSTR_W-1:0] OP_RET_V  = 14'h0008;
  localparam logic [INSTR_W-1:0] OP_RFI_V  = 14'h0009;
  localparam logic [INSTR_W-1:0] OP_FULL_M = 14'h3fff;
  localparam logic [INSTR_W-1:0] OP_RLW_V  = 14'h3400;
  localparam logic [INSTR_W-1:0] OP_RLW_M  = 14'h3f00;
  localparam logic [INSTR_W-1:0] OP_ROT_V  = 14'h0d00;
  localparam logic [INSTR_W-1:0] OP_ROT_M  = 14'h3f00;

  // Cycle counts
  localparam int unsigned CYC_ONE = 1;
  localparam int unsigned CYC_TWO = 2;

  typedef enum logic [8:0] {
    CBR_OP_NONE = 9'h000,
    CBR_OP_CLR  = 9'h001,
    CBR_OP_SET  = 9'h002,
    CBR_OP_TSC  = 9'h004,
    CBR_OP_TSS  = 9'h008,
    CBR_OP_RJL  = 9'h010,
    CBR_OP_RJA  = 9'h020,
    CBR_OP_RFI  = 9'h040,
    CBR_OP_RET  = 9'h080,
    CBR_OP_RLW  = 9'h100
  } cbr_op_e;

endpackage

// ===== src/cbr_stack.sv
// Purpose: Hardware return stack with push and pop
// Assumes: Push and pop never requested in the same cycle
// Notes:   Top entry visible combinationally at the pointer
`timescale 1ns/10ps
module cbr_stack
  import cbr_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  input  wire logic            core_clk,  // Core clock
  input  wire logic            nrst,      // Sync reset, active low
  input  wire logic            push,      // Save an address
  input  wire logic [PC_W-1:0] push_addr, // Address to save
  input  wire logic            pop,       // Drop top entry
  output logic      [PC_W-1:0] top_entry  // Stack top entry
);

  logic [PC_W-1:0] mem_r [DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [SP_W-1:0] sp_nxt;
  logic [SP_W-1:0] sp_up;

  assign sp_up     = sp_r + 4'h1;
  assign top_entry = mem_r[sp_r];

  always_comb begin
    sp_nxt = sp_r;
    if (push) begin
      sp_nxt = sp_up;
    end else if (pop) begin
      sp_nxt = sp_r - 4'h1; // [RULE_12]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sp_r <= SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[sp_up] <= push_addr;
    end
  end

endmodule
